// ---- pkg/bridge_cfg_map.svh ----
`ifndef BRIDGE_CFG_MAP_SVH
`define BRIDGE_CFG_MAP_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define IDX_BRIDGE_SUBCLASS_CODE    8'h0A
`define IDX_BRIDGE_BASE_CLASS_CODE  8'h0B
`define IDX_LATENCY_SCRATCHPAD      8'h0D
`define IDX_HEADER_LAYOUT_TYPE      8'h0E
`define IDX_UPSTREAM_BUS_NUMBER     8'h18
`define IDX_DOWNSTREAM_BUS_NUMBER   8'h19
`define IDX_HIGHEST_BUS_BEHIND      8'h1A
`define IDX_DECODE_STATUS           8'h30

// ----------------------------------------------------------------------
// Fixed codes and reset values
// ----------------------------------------------------------------------
`define VAL_BRIDGE_CATEGORY         8'h04
`define VAL_CLASS_CATEGORY          8'h06
`define VAL_LAYOUT_TYPE             8'h01
`define VAL_UPSTREAM_BUS            8'h00
`define RST_LATENCY_SCRATCHPAD      8'h00
`define RST_DOWNSTREAM_BUS          8'h00
`define RST_HIGHEST_BUS             8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define SCRATCH_BITS_MSB            7
`define SCRATCH_BITS_LSB            3
`define SCRATCH_BITS_MASK           8'hF8
`define STATUS_WINDOW_VALID_BIT     0
`define STATUS_LAST_CLAIM_BIT       1

// ----------------------------------------------------------------------
// Bus geometry
// ----------------------------------------------------------------------
`define APB_ADDR_WIDTH              12
`define APB_DATA_WIDTH              32
`define APB_WORD_ADDR_LSB           2

`endif

// ---- pkg/bridge_cfg_pkg.sv ----
`include "bridge_cfg_map.svh"

package bridge_cfg_pkg;

   // ----------------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------------
   typedef logic [`APB_ADDR_WIDTH-1:0] apb_addr_t;
   typedef logic [`APB_DATA_WIDTH-1:0] apb_data_t;
   typedef logic [7:0]                 bus_num_t;

   typedef enum logic [2:0] {
      PH_IDLE   = 3'b001,
      PH_SETUP  = 3'b010,
      PH_ACCESS = 3'b100
   } apb_phase_e;

   typedef struct packed {
      apb_phase_e phase;
      logic [4:0] scratch_bits;
      bus_num_t   downstream_bus_field;
      bus_num_t   highest_bus_field;
      apb_data_t  prdata;
      logic       pslverr;
   } regs_s;

   typedef struct packed {
      logic claim;
      logic window_valid;
   } decode_s;

endpackage

// ---- hdl/bus_range_decoder.sv ----
`timescale 1ns/10ps
`default_nettype none

module bus_range_decoder
   import bridge_cfg_pkg::*;
(
   input  wire logic                      clk_in,
   input  wire logic                      rst_b_in,
   input  wire bridge_cfg_pkg::bus_num_t  target_bus_in,
   input  wire logic                      target_valid_in,
   input  wire bridge_cfg_pkg::bus_num_t  downstream_bus_in,
   input  wire bridge_cfg_pkg::bus_num_t  highest_bus_in,
   output logic                           claim_out,
   output logic                           window_valid_out
);

   decode_s state_r;
   decode_s state_nxt;

   // ----------------------------------------------------------------------
   // Range check
   // ----------------------------------------------------------------------
   // An inverted window (highest below downstream) claims nothing, so a pair with only
   // the downstream number written (above 0) cannot steal cycles meant for bus 0.
   always_comb begin
      state_nxt              = state_r;
      state_nxt.window_valid = (highest_bus_in >= downstream_bus_in);
      state_nxt.claim        = target_valid_in
                               && (target_bus_in >= downstream_bus_in)
                               && (target_bus_in <= highest_bus_in);
   end

   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         state_r <= '0;
      end else begin
         state_r <= state_nxt;
      end
   end

   assign claim_out        = state_r.claim;
   assign window_valid_out = state_r.window_valid;

endmodule // bus_range_decoder

`default_nettype wire

// ---- hdl/bridge_cfg_header.sv ----
// Operation
// - Sub-class byte is read-only and always returns code 04h.
// - Base-class byte is read-only and always returns code 06h.
// - Latency byte bits 7:3 are plain scratch storage with no internal effect.
// - Header-type byte always reads 01, single function with bridge layout.
// - Header-type location has no storage; writes there do nothing.
// - Upstream bus number reads as zero and cannot be written.
// - Downstream bus number is written by software; all eight bits read back.
// - Highest bus behind is software-programmed, stored and returned.
`timescale 1ns/10ps
`default_nettype none

`include "bridge_cfg_map.svh"

module bridge_cfg_header (
   input  wire logic                       CORE_CLK_IN,
   input  wire logic                       RST_B_IN,
   input  wire logic                       PSEL_IN,
   input  wire logic                       PENABLE_IN,
   input  wire logic                       PWRITE_IN,
   input  wire bridge_cfg_pkg::apb_addr_t  PADDR_IN,
   input  wire bridge_cfg_pkg::apb_data_t  PWDATA_IN,
   input  wire logic [3:0]                 PSTRB_IN,
   output logic                            PREADY_OUT,
   output bridge_cfg_pkg::apb_data_t       PRDATA_OUT,
   output logic                            PSLVERR_OUT,
   input  wire bridge_cfg_pkg::bus_num_t   TARGET_BUS_IN,
   input  wire logic                       TARGET_VALID_IN,
   output logic                            CLAIM_OUT,
   output bridge_cfg_pkg::bus_num_t        DOWNSTREAM_BUS_OUT,
   output bridge_cfg_pkg::bus_num_t        HIGHEST_BUS_OUT
);

   import bridge_cfg_pkg::*;

   // ----------------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------------
   localparam int NUM_REGS = 8;

   localparam logic [7:0] REG_INDEX [NUM_REGS] = '{
      `IDX_BRIDGE_SUBCLASS_CODE,
      `IDX_BRIDGE_BASE_CLASS_CODE,
      `IDX_LATENCY_SCRATCHPAD,
      `IDX_HEADER_LAYOUT_TYPE,
      `IDX_UPSTREAM_BUS_NUMBER,
      `IDX_DOWNSTREAM_BUS_NUMBER,
      `IDX_HIGHEST_BUS_BEHIND,
      `IDX_DECODE_STATUS
   };

   localparam int SEL_SUBCLASS   = 0;
   localparam int SEL_BASE_CLASS = 1;
   localparam int SEL_LATENCY    = 2;
   localparam int SEL_LAYOUT     = 3;
   localparam int SEL_UPSTREAM   = 4;
   localparam int SEL_DOWNSTREAM = 5;
   localparam int SEL_HIGHEST    = 6;
   localparam int SEL_STATUS     = 7;

   regs_s               regs_r;
   regs_s               regs_nxt;
   logic [NUM_REGS-1:0] hit;
   logic                addr_aligned;
   logic                addr_in_page;
   logic                addr_mapped;
   logic [7:0]          word_index;
   logic                setup_phase;
   logic                access_done;
   logic                wr_done;
   logic                low_lane;
   logic [7:0]          wr_byte;
   logic [7:0]          rd_byte;
   logic                claim;
   logic                window_valid;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------
   // Each register occupies one aligned word; unaligned addresses and
   // indices beyond eight bits are refused with an error.
   assign addr_aligned = (PADDR_IN[`APB_WORD_ADDR_LSB-1:0] == 2'h0);
   assign addr_in_page = (PADDR_IN[`APB_ADDR_WIDTH-1:`APB_WORD_ADDR_LSB+8]
                          == 2'h0);
   assign word_index   = PADDR_IN[`APB_WORD_ADDR_LSB+7:`APB_WORD_ADDR_LSB];

   genvar g;
   generate
      for (g = 0; g < NUM_REGS; g = g + 1) begin : g_hit
         assign hit[g] = addr_aligned && addr_in_page
                         && (word_index == REG_INDEX[g]);
      end
   endgenerate

   assign addr_mapped = |hit;

   // ----------------------------------------------------------------------
   // Transfer phases
   // ----------------------------------------------------------------------
   // The slave never inserts wait states: the access phase completes at
   // its first edge, so read data is prepared during the setup cycle.
   assign setup_phase = PSEL_IN && !PENABLE_IN;
   assign access_done = PSEL_IN && PENABLE_IN;
   assign PREADY_OUT  = access_done;
   // A write commits only in an access phase that followed a setup cycle,
   // so a stray enable without a setup cannot disturb the stored bytes.
   assign wr_done     = access_done && (regs_r.phase == PH_SETUP)
                        && PWRITE_IN && addr_mapped;
   assign low_lane    = PSTRB_IN[0];
   assign wr_byte     = PWDATA_IN[7:0];

   // ----------------------------------------------------------------------
   // Read multiplexer
   // ----------------------------------------------------------------------
   always_comb begin
      rd_byte = 8'h00;
      case (1'b1)
         hit[SEL_SUBCLASS]: begin
            rd_byte = `VAL_BRIDGE_CATEGORY;
         end
         hit[SEL_BASE_CLASS]: begin
            rd_byte = `VAL_CLASS_CATEGORY;
         end
         hit[SEL_LATENCY]: begin
            // The low three bits are reserved and always zero.
            rd_byte = {regs_r.scratch_bits, 3'h0};
         end
         hit[SEL_LAYOUT]: begin
            rd_byte = `VAL_LAYOUT_TYPE;
         end
         hit[SEL_UPSTREAM]: begin
            rd_byte = `VAL_UPSTREAM_BUS;
         end
         hit[SEL_DOWNSTREAM]: begin
            rd_byte = regs_r.downstream_bus_field;
         end
         hit[SEL_HIGHEST]: begin
            rd_byte = regs_r.highest_bus_field;
         end
         hit[SEL_STATUS]: begin
            rd_byte = 8'h00;
            rd_byte[`STATUS_WINDOW_VALID_BIT] = window_valid;
            rd_byte[`STATUS_LAST_CLAIM_BIT]   = claim;
         end
         default: begin
            rd_byte = 8'h00;
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // Next-state logic
   // ----------------------------------------------------------------------
   always_comb begin
      regs_nxt = regs_r;

      case (regs_r.phase)
         PH_IDLE: begin
            if (setup_phase) begin
               regs_nxt.phase = PH_SETUP;
            end
         end
         PH_SETUP: begin
            if (access_done) begin
               regs_nxt.phase = PH_ACCESS;
            end else if (!PSEL_IN) begin
               regs_nxt.phase = PH_IDLE;
            end
         end
         PH_ACCESS: begin
            if (setup_phase) begin
               regs_nxt.phase = PH_SETUP;
            end else begin
               regs_nxt.phase = PH_IDLE;
            end
         end
         default: begin
            regs_nxt.phase = PH_IDLE;
         end
      endcase

      // Read data and error are captured in the setup cycle and held
      // through the access phase; upper 24 bits always read as zero.
      if (setup_phase) begin
         regs_nxt.pslverr = !addr_mapped;
         if (!PWRITE_IN) begin
            regs_nxt.prdata = {24'h000000, rd_byte};
         end else begin
            regs_nxt.prdata = '0;
         end
      end

      // Only the low byte lane carries data. Writes to the read-only
      // codes, the layout byte and the status word are dropped, because
      // none of them has a storage element behind it.
      if (wr_done && low_lane) begin
         if (hit[SEL_LATENCY]) begin
            regs_nxt.scratch_bits =
               wr_byte[`SCRATCH_BITS_MSB:`SCRATCH_BITS_LSB];
         end
         if (hit[SEL_DOWNSTREAM]) begin
            regs_nxt.downstream_bus_field = wr_byte;
         end
         if (hit[SEL_HIGHEST]) begin
            regs_nxt.highest_bus_field = wr_byte;
         end
      end
   end

   // ----------------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------------
   always_ff @(posedge CORE_CLK_IN) begin
      if (!RST_B_IN) begin
         regs_r.phase                <= PH_IDLE;
         regs_r.scratch_bits         <= 5'h00;
         regs_r.downstream_bus_field <= `RST_DOWNSTREAM_BUS;
         regs_r.highest_bus_field    <= `RST_HIGHEST_BUS;
         regs_r.prdata               <= '0;
         regs_r.pslverr              <= 1'b0;
      end else begin
         regs_r <= regs_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Bus-number window decode
   // ----------------------------------------------------------------------
   bus_range_decoder u_range (
      .clk_in            (CORE_CLK_IN),
      .rst_b_in          (RST_B_IN),
      .target_bus_in     (TARGET_BUS_IN),
      .target_valid_in   (TARGET_VALID_IN),
      .downstream_bus_in (regs_r.downstream_bus_field),
      .highest_bus_in    (regs_r.highest_bus_field),
      .claim_out         (claim),
      .window_valid_out  (window_valid)
   );

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   // Error is only shown in the access phase, as the bus requires.
   assign PRDATA_OUT         = regs_r.prdata;
   assign PSLVERR_OUT        = regs_r.pslverr && access_done;
   assign CLAIM_OUT          = claim;
   assign DOWNSTREAM_BUS_OUT = regs_r.downstream_bus_field;
   assign HIGHEST_BUS_OUT    = regs_r.highest_bus_field;

endmodule // bridge_cfg_header

`default_nettype wire

// ---- verif/bridge_cfg_header_props.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bridge_cfg_map.svh"
module bridge_cfg_header_props (
   input wire logic                      CORE_CLK_IN,
   input wire logic                      RST_B_IN,
   input wire logic                      PSEL_IN,
   input wire logic                      PENABLE_IN,
   input wire logic                      PWRITE_IN,
   input wire bridge_cfg_pkg::apb_addr_t PADDR_IN,
   input wire bridge_cfg_pkg::apb_data_t PWDATA_IN,
   input wire logic [3:0]                PSTRB_IN,
   input wire logic                      PREADY_OUT,
   input wire bridge_cfg_pkg::apb_data_t PRDATA_OUT,
   input wire logic                      PSLVERR_OUT,
   input wire bridge_cfg_pkg::bus_num_t  TARGET_BUS_IN,
   input wire logic                      TARGET_VALID_IN,
   input wire logic                      CLAIM_OUT,
   input wire bridge_cfg_pkg::bus_num_t  DOWNSTREAM_BUS_OUT,
   input wire bridge_cfg_pkg::bus_num_t  HIGHEST_BUS_OUT
);
   import bridge_cfg_pkg::*;
   logic       in_window;
   logic [7:0] wlow;
   assign wlow = PWDATA_IN[7:0];
   assign in_window = TARGET_VALID_IN && TARGET_BUS_IN >= DOWNSTREAM_BUS_OUT
                      && TARGET_BUS_IN <= HIGHEST_BUS_OUT;
   default clocking @(posedge CORE_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // ------------------------------------------------------------------
   // Bus phases
   // ------------------------------------------------------------------
   sequence rd_setup(logic [7:0] i);
      PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == {2'b00, i, 2'b00};
   endsequence
   sequence wr_access(logic [7:0] i);
      PSEL_IN && PENABLE_IN && PWRITE_IN && PSTRB_IN[0]
      && PADDR_IN == {2'b00, i, 2'b00};
   endsequence
   chk_ready_zero_wait: assert property (
      PREADY_OUT == (PSEL_IN && PENABLE_IN)) else $error("ready wrong");
   chk_unaligned_error: assert property (
      PSEL_IN && PENABLE_IN && PADDR_IN[1:0] != 2'h0 |-> PSLVERR_OUT)
      else $error("unaligned access not refused");
   chk_subclass_value: assert property (
      rd_setup(`IDX_BRIDGE_SUBCLASS_CODE) |=>
      PRDATA_OUT == {24'h0, `VAL_BRIDGE_CATEGORY}) else $error("subclass");
   chk_base_class_value: assert property (
      rd_setup(`IDX_BRIDGE_BASE_CLASS_CODE) |=>
      PRDATA_OUT == {24'h0, `VAL_CLASS_CATEGORY}) else $error("class");
   chk_layout_value: assert property (
      rd_setup(`IDX_HEADER_LAYOUT_TYPE) |=>
      PRDATA_OUT == {24'h0, `VAL_LAYOUT_TYPE}) else $error("layout");
   chk_upstream_zero: assert property (
      rd_setup(`IDX_UPSTREAM_BUS_NUMBER) |=> PRDATA_OUT == 32'h0)
      else $error("upstream not zero");
   chk_scratch_reserved: assert property (
      rd_setup(`IDX_LATENCY_SCRATCHPAD) |=> PRDATA_OUT[2:0] == 3'h0
      && PRDATA_OUT[31:8] == 24'h0) else $error("reserved bits set");
   chk_downstream_store: assert property (
      wr_access(`IDX_DOWNSTREAM_BUS_NUMBER) |=>
      DOWNSTREAM_BUS_OUT == $past(wlow)) else $error("downstream store");
   chk_highest_store: assert property (
      wr_access(`IDX_HIGHEST_BUS_BEHIND) |=>
      HIGHEST_BUS_OUT == $past(wlow)) else $error("highest store");
   chk_claim_window: assert property (
      $past(RST_B_IN) |-> CLAIM_OUT == $past(in_window))
      else $error("claim wrong");
endmodule // bridge_cfg_header_props
`default_nettype wire

// ---- verif/test_bridge_cfg_header.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bridge_cfg_map.svh"
module test_bridge_cfg_header;
   import bridge_cfg_pkg::*;
   logic       clk, rst_b, psel, penable, pwrite, pready, pslverr;
   logic       tvalid, claim, err;
   logic [3:0] pstrb;
   apb_addr_t  paddr;
   apb_data_t  pwdata, prdata, rd;
   bus_num_t   tbus, dbus, hbus;
   int         bad_count, samples_checked;
   localparam logic [7:0] IDX [7] = '{`IDX_BRIDGE_SUBCLASS_CODE,
      `IDX_BRIDGE_BASE_CLASS_CODE, `IDX_LATENCY_SCRATCHPAD,
      `IDX_HEADER_LAYOUT_TYPE, `IDX_UPSTREAM_BUS_NUMBER,
      `IDX_DOWNSTREAM_BUS_NUMBER, `IDX_HIGHEST_BUS_BEHIND};
   localparam logic [7:0] RST [7] = '{`VAL_BRIDGE_CATEGORY,
      `VAL_CLASS_CATEGORY, `RST_LATENCY_SCRATCHPAD, `VAL_LAYOUT_TYPE,
      `VAL_UPSTREAM_BUS, `RST_DOWNSTREAM_BUS, `RST_HIGHEST_BUS};
   localparam logic [7:0] ONES [7] = '{`VAL_BRIDGE_CATEGORY,
      `VAL_CLASS_CATEGORY, `SCRATCH_BITS_MASK, `VAL_LAYOUT_TYPE,
      `VAL_UPSTREAM_BUS, 8'hFF, 8'hFF};
   bridge_cfg_header u_bridge_cfg_header (.CORE_CLK_IN(clk),
      .RST_B_IN(rst_b), .PSEL_IN(psel), .PENABLE_IN(penable),
      .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PSTRB_IN(pstrb), .PREADY_OUT(pready), .PRDATA_OUT(prdata),
      .PSLVERR_OUT(pslverr), .TARGET_BUS_IN(tbus),
      .TARGET_VALID_IN(tvalid), .CLAIM_OUT(claim),
      .DOWNSTREAM_BUS_OUT(dbus), .HIGHEST_BUS_OUT(hbus));
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // ------------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic check_data(apb_data_t got, apb_data_t exp);
      samples_checked++;
      if (got !== exp) begin
         $display("ERROR %0t data %h expected %h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic check_bit(logic got, logic exp);
      samples_checked++;
      if (got !== exp) begin
         $display("ERROR %0t flag %b expected %b", $time, got, exp);
         bad_count++;
      end
   endtask
   // The request is held until ready is seen at a rising edge.
   task automatic xfer(logic w, apb_addr_t a, apb_data_t d, logic [3:0] s);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         bad_count++;
         tally_and_finish();
      end else begin
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   task automatic apb(logic w, logic [7:0] i, apb_data_t d, logic [3:0] s);
      xfer(w, apb_addr_t'({i, 2'b00}), d, s);
   endtask
   // Unaligned or out-of-page addresses must be refused with an error.
   task automatic refused(logic w, apb_addr_t a);
      xfer(w, a, 32'h0000_0044, {4{w}});
      if (!w) begin
         check_data(rd, 32'h0);
      end
      check_bit(err, 1'b1);
   endtask
   task automatic status_chk(bus_num_t t, logic v, logic [7:0] e);
      @(posedge clk);
      tbus <= t;
      tvalid <= v;
      rd_chk(`IDX_DECODE_STATUS, e, 1'b0);
      tvalid <= 1'b0;
   endtask
   task automatic rd_chk(logic [7:0] i, logic [7:0] e, logic e_err);
      apb(1'b0, i, 32'h0, 4'h0);
      check_data(rd, {24'h0, e});
      check_bit(err, e_err);
   endtask
   task automatic probe(bus_num_t t, logic v, logic e);
      @(posedge clk);
      tbus <= t;
      tvalid <= v;
      repeat (2) @(posedge clk);
      check_bit(claim, e);
      tvalid <= 1'b0;
   endtask
   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic test_reset_and_ro();
      foreach (IDX[k]) begin
         rd_chk(IDX[k], RST[k], 1'b0);
         apb(1'b1, IDX[k], 32'hFFFF_FFFF, 4'hF);
      end
      foreach (IDX[k]) begin
         rd_chk(IDX[k], ONES[k], 1'b0);
      end
   endtask
   task automatic test_scratch_strobe();
      apb(1'b1, `IDX_LATENCY_SCRATCHPAD, 32'h0000_0053, 4'hF);
      rd_chk(`IDX_LATENCY_SCRATCHPAD, 8'h50, 1'b0);
      apb(1'b1, `IDX_DOWNSTREAM_BUS_NUMBER, 32'h0000_0012, 4'h0);
      refused(1'b1, 12'h065);
      refused(1'b1, 12'h464);
      rd_chk(`IDX_DOWNSTREAM_BUS_NUMBER, 8'hFF, 1'b0);
      rd_chk(8'h0C, 8'h00, 1'b1);
      refused(1'b0, 12'h428);
   endtask
   task automatic test_mid_reset();
      @(posedge clk);
      rst_b <= 1'b0;
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      foreach (IDX[k]) begin
         rd_chk(IDX[k], RST[k], 1'b0);
      end
      check_bit(claim, 1'b0);
   endtask
   task automatic test_claim();
      apb(1'b1, `IDX_DOWNSTREAM_BUS_NUMBER, 32'h0000_0005, 4'hF);
      apb(1'b1, `IDX_HIGHEST_BUS_BEHIND, 32'h0000_0009, 4'hF);
      @(posedge clk);
      check_data({16'h0, dbus, hbus}, 32'h0000_0509);
      probe(8'h04, 1'b1, 1'b0);
      probe(8'h05, 1'b1, 1'b1);
      probe(8'h07, 1'b1, 1'b1);
      probe(8'h09, 1'b1, 1'b1);
      probe(8'h0A, 1'b1, 1'b0);
      probe(8'h07, 1'b0, 1'b0);
      status_chk(8'h07, 1'b1, 8'h03);
      apb(1'b1, `IDX_DOWNSTREAM_BUS_NUMBER, 32'h0000_0009, 4'hF);
      apb(1'b1, `IDX_HIGHEST_BUS_BEHIND, 32'h0000_0005, 4'hF);
      probe(8'h07, 1'b1, 1'b0);
      status_chk(8'h07, 1'b1, 8'h00);
   endtask
   initial begin
      {rst_b, psel, penable, pwrite, tvalid} = '0;
      paddr = '0;
      pwdata = '0;
      pstrb = '0;
      tbus = '0;
      bad_count = 0;
      samples_checked = 0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      test_reset_and_ro();
      test_scratch_strobe();
      test_claim();
      test_mid_reset();
      tally_and_finish();
   end
endmodule // test_bridge_cfg_header
bind bridge_cfg_header bridge_cfg_header_props u_bridge_cfg_header_props (
   .CORE_CLK_IN(CORE_CLK_IN), .RST_B_IN(RST_B_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
   .PWDATA_IN(PWDATA_IN), .PSTRB_IN(PSTRB_IN), .PREADY_OUT(PREADY_OUT),
   .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT),
   .TARGET_BUS_IN(TARGET_BUS_IN), .TARGET_VALID_IN(TARGET_VALID_IN),
   .CLAIM_OUT(CLAIM_OUT), .DOWNSTREAM_BUS_OUT(DOWNSTREAM_BUS_OUT),
   .HIGHEST_BUS_OUT(HIGHEST_BUS_OUT));
`default_nettype wire
